//--- logic/stack_push_rotate_repeat_exec.sv
// Execution unit for word push, flag-word push, carry rotates and the
// repeat prefix. Software loads registers over APB and writes CTRL to run.
// Assumes a memory port taking one byte per valid/ready handshake, an outside
// string primitive unit, and an interrupt controller that signals return.
`timescale 1ns/100ps
`default_nettype none

module stack_push_rotate_repeat_exec
  import exec_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  output mem_req_type       mem_req,
  input  wire logic         mem_ready,
  output logic              str_req,
  output logic              str_extra,
  input  wire str_resp_type str_resp,
  input  wire logic         irq,
  input  wire logic         nmi,
  output logic              int_req,
  output logic              int_nmi,
  input  wire logic         int_done
);

  typedef struct packed {
    exec_state_type    st;
    logic [7:0][15:0]  gpr;
    logic [3:0][15:0]  seg;
    logic [15:0]       flags;
    logic [15:0]       operand;
    logic [15:0]       result;
    logic [15:0]       val;
    logic [31:0]       instr;
    logic [31:0]       rdata;
    logic [7:0]        temp;
    logic [7:0]        cnt;
    logic              cf;
    logic              busy;
    logic              done;
    logic              err;
    logic              extra;
    mem_req_type       mem;
    logic              str_req;
    logic              int_req;
    logic              int_nmi;
  } core_state_type;

  core_state_type s_q;
  core_state_type s_d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic msb_of(input logic [15:0] v, input logic w);
    msb_of = w ? v[15] : v[7];
  endfunction

  // Byte registers 0-3 are low halves, 4-7 the high halves of words 0-3
  function automatic logic [15:0] reg_value(input core_state_type s,
                                            input logic [2:0] r, input logic w);
    if (w)
      reg_value = s.gpr[r];
    else if (r[2])
      reg_value = {8'h00, s.gpr[{1'b0, r[1:0]}][15:8]};
    else
      reg_value = {8'h00, s.gpr[{1'b0, r[1:0]}][7:0]};
  endfunction

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a[1:0] == 2'b00) &&
                (a <= RESULT_OFS || (a >= GPR_BASE && a < SEG_BASE + 12'h010));
  endfunction

  function automatic logic [31:0] read_word(input core_state_type s,
                                            input logic [11:0] a);
    logic [11:0] g;
    logic [11:0] k;
    g = a - GPR_BASE;
    k = a - SEG_BASE;
    read_word = 32'h0000_0000;
    if (a == INSTR_OFS)
      read_word = s.instr;
    else if (a == OPERAND_OFS)
      read_word = {16'h0000, s.operand};
    else if (a == FLAGS_OFS)
      read_word = {16'h0000, s.flags};
    else if (a == STATUS_OFS)
      read_word = {24'h00_0000, s.st, s.extra, s.err, s.done, s.busy};
    else if (a == RESULT_OFS)
      read_word = {16'h0000, s.result};
    else if (a >= GPR_BASE && a < SEG_BASE)
      read_word = {16'h0000, s.gpr[g[4:2]]};
    else if (a >= SEG_BASE && a < SEG_BASE + 12'h010)
      read_word = {16'h0000, s.seg[k[3:2]]};
  endfunction

  // ****************************************
  // Next-state logic
  // ****************************************
  logic [7:0]  op;
  logic [7:0]  modrm;
  logic [7:0]  pfx;
  logic        rep_pfx;
  logic        w_bit;
  logic [15:0] sp_now;
  logic [16:0] step;
  logic [11:0] gofs;
  logic [11:0] sofs;

  always_comb
  begin
    s_d = s_q;
    op = s_q.instr[7:0];
    modrm = s_q.instr[15:8];
    pfx = s_q.instr[23:16];
    rep_pfx = (pfx[7:1] == OP_REPEAT);
    w_bit = op[0];
    sp_now = s_q.gpr[STACK_IDX];
    step = 17'h0_0000;
    gofs = paddr - GPR_BASE;
    sofs = paddr - SEG_BASE;

    // Read data is captured in the setup phase so it leaves a flip-flop
    if (psel && !penable)
      s_d.rdata = read_word(s_q, paddr);

    // Software writes land only while idle, so a running op sees stable inputs
    if (psel && penable && pwrite && !s_q.busy)
    begin
      if (paddr == CTRL_OFS && pwdata[0])
      begin
        s_d.busy = 1'b1;
        s_d.done = 1'b0;
        s_d.err = 1'b0;
        s_d.extra = |s_q.instr[31:24];
        s_d.st = ST_DECODE;
      end
      else if (paddr == INSTR_OFS)
        s_d.instr = pwdata;
      else if (paddr == OPERAND_OFS)
        s_d.operand = pwdata[15:0];
      else if (paddr == FLAGS_OFS)
        s_d.flags = pwdata[15:0];
      else if (paddr >= GPR_BASE && paddr < SEG_BASE)
        s_d.gpr[gofs[4:2]] = pwdata[15:0];
      else if (paddr >= SEG_BASE && paddr < SEG_BASE + 12'h010)
        s_d.seg[sofs[3:2]] = pwdata[15:0];
    end

    case (s_q.st)
      ST_IDLE:
      begin
        s_d.mem.valid = 1'b0;
      end

      ST_DECODE:
      begin
        if (rep_pfx)
          s_d.st = ST_REP_CHK;
        else if ((op == OP_GROUP_FF && modrm[5:3] == SUB_PUSH) ||
                 op[7:3] == OP_PUSH_REG ||
                 (op[7:5] == OP_SEG_HI && op[2:0] == OP_SEG_LO) ||
                 op == OP_PUSH_FLAGS)
        begin
          if (op == OP_PUSH_FLAGS)
            s_d.val = s_q.flags;
          else if (op[7:3] == OP_PUSH_REG)
            s_d.val = s_q.gpr[op[2:0]];
          else if (op[7:5] == OP_SEG_HI)
            s_d.val = s_q.seg[op[4:3]];
          else if (modrm[7:6] == MOD_REG)
            s_d.val = s_q.gpr[modrm[2:0]];
          else
            s_d.val = s_q.operand;
          // Pointer moves before any byte is written; flags untouched
          s_d.gpr[STACK_IDX] = sp_now - PUSH_STEP;
          s_d.st = ST_PUSH_LO;
        end
        else if (op[7:2] == OP_ROTATE &&
                 (modrm[5:3] == SUB_RCL || modrm[5:3] == SUB_RCR))
        begin
          s_d.val = (modrm[7:6] == MOD_REG) ? reg_value(s_q, modrm[2:0], w_bit)
                                            : (w_bit ? s_q.operand
                                                     : {8'h00, s_q.operand[7:0]});
          s_d.cf = s_q.flags[CARRY_BIT];
          s_d.cnt = op[1] ? s_q.gpr[COUNT_IDX][7:0] : 8'h01;
          s_d.temp = op[1] ? s_q.gpr[COUNT_IDX][7:0] : 8'h01;
          s_d.st = ST_ROT;
        end
        else
        begin
          s_d.err = 1'b1;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end

      ST_PUSH_LO:
      begin
        s_d.mem = '{valid: 1'b1, addr: sp_now, data: s_q.val[7:0]};
        if (s_q.mem.valid && mem_ready)
        begin
          s_d.mem = '{valid: 1'b1, addr: sp_now + 16'h0001, data: s_q.val[15:8]};
          s_d.st = ST_PUSH_HI;
        end
      end

      ST_PUSH_HI:
      begin
        if (mem_ready)
        begin
          s_d.mem.valid = 1'b0;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end

      ST_ROT:
      begin
        if (s_q.temp != 8'h00)
        begin
          if (modrm[5:3] == SUB_RCL)
            step = {msb_of(s_q.val, w_bit), s_q.val[14:0], s_q.cf};
          else if (w_bit)
            step = {s_q.val[0], s_q.cf, s_q.val[15:1]};
          else
            step = {s_q.val[0], 8'h00, s_q.cf, s_q.val[7:1]};
          s_d.cf = step[16];
          s_d.val = w_bit ? step[15:0] : {8'h00, step[7:0]};
          s_d.temp = s_q.temp - 8'h01;
        end
        else
        begin
          s_d.flags[CARRY_BIT] = s_q.cf;
          // Overflow is left as it was for any count other than one
          if (s_q.cnt == 8'h01 && modrm[5:3] == SUB_RCL)
            s_d.flags[OVERFLOW_BIT] = msb_of(s_q.val, w_bit) ^ s_q.cf;
          else if (s_q.cnt == 8'h01)
            s_d.flags[OVERFLOW_BIT] = w_bit ? s_q.val[15] ^ s_q.val[14]
                                            : s_q.val[7] ^ s_q.val[6];
          if (modrm[7:6] != MOD_REG)
            s_d.result = s_q.val;
          else if (w_bit)
            s_d.gpr[modrm[2:0]] = s_q.val;
          else if (modrm[2])
            s_d.gpr[{1'b0, modrm[1:0]}][15:8] = s_q.val[7:0];
          else
            s_d.gpr[{1'b0, modrm[1:0]}][7:0] = s_q.val[7:0];
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
      end

      ST_REP_CHK:
      begin
        if (s_q.gpr[COUNT_IDX] == 16'h0000)
        begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
          s_d.st = ST_IDLE;
        end
        else if (nmi || (irq && s_q.flags[IRQ_EN_BIT]))
        begin
          // Only the repeat prefix survives; overrides are dropped here
          s_d.extra = 1'b0;
          s_d.int_req = 1'b1;
          s_d.int_nmi = nmi;
          s_d.st = ST_REP_INT;
        end
        else
        begin
          s_d.str_req = 1'b1;
          s_d.st = ST_REP_STR;
        end
      end

      ST_REP_INT:
      begin
        // Count and state are held across the handler, then the element runs
        if (int_done)
        begin
          s_d.int_req = 1'b0;
          s_d.int_nmi = 1'b0;
          s_d.str_req = 1'b1;
          s_d.st = ST_REP_STR;
        end
      end

      ST_REP_STR:
      begin
        if (str_resp.ack)
        begin
          s_d.str_req = 1'b0;
          // Only compare and scan post the zero flag; the prefix never does
          if (str_resp.compare)
            s_d.flags[ZERO_BIT] = str_resp.zero_flag;
          s_d.gpr[COUNT_IDX] = s_q.gpr[COUNT_IDX] - 16'h0001;
          if (str_resp.compare && str_resp.zero_flag != pfx[0])
          begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
            s_d.st = ST_IDLE;
          end
          else
            s_d.st = ST_REP_CHK;
        end
      end

      default:
      begin
        s_d.st = ST_IDLE;
        s_d.busy = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q <= '0;
      s_q.flags <= FLAGS_RST;
      s_q.st <= ST_IDLE;
    end
    else
      s_q <= s_d;
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !is_mapped(paddr);
  assign prdata = s_q.rdata;
  assign mem_req = s_q.mem;
  assign str_req = s_q.str_req;
  assign str_extra = s_q.extra;
  assign int_req = s_q.int_req;
  assign int_nmi = s_q.int_nmi;

endmodule

`default_nettype wire

//--- logic/exec_pkg.sv
// Package for the stack push, carry rotate and repeat-prefix execution block.
// Assumes an APB master on one 100 MHz clock and byte-wide memory writes.
package exec_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] INSTR_OFS   = 12'h004;
  localparam logic [11:0] OPERAND_OFS = 12'h008;
  localparam logic [11:0] FLAGS_OFS   = 12'h00c;
  localparam logic [11:0] STATUS_OFS  = 12'h010;
  localparam logic [11:0] RESULT_OFS  = 12'h014;
  localparam logic [11:0] GPR_BASE    = 12'h020;
  localparam logic [11:0] SEG_BASE    = 12'h040;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CARRY_BIT    = 0;
  localparam int ZERO_BIT     = 6;
  localparam int IRQ_EN_BIT   = 9;
  localparam int OVERFLOW_BIT = 11;
  localparam int COUNT_IDX    = 1;
  localparam int STACK_IDX    = 4;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] PUSH_STEP = 16'h0002;

  // ****************************************
  // Opcode patterns
  // ****************************************
  localparam logic [7:0] OP_GROUP_FF   = 8'hff;
  localparam logic [2:0] SUB_PUSH      = 3'b110;
  localparam logic [4:0] OP_PUSH_REG   = 5'b01010;
  localparam logic [2:0] OP_SEG_HI     = 3'b000;
  localparam logic [2:0] OP_SEG_LO     = 3'b110;
  localparam logic [7:0] OP_PUSH_FLAGS = 8'h9d;
  localparam logic [5:0] OP_ROTATE     = 6'b110100;
  localparam logic [2:0] SUB_RCL       = 3'b010;
  localparam logic [2:0] SUB_RCR       = 3'b011;
  localparam logic [6:0] OP_REPEAT     = 7'b1111001;
  localparam logic [1:0] MOD_REG       = 2'b11;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0000,
    ST_DECODE  = 4'b0001,
    ST_PUSH_LO = 4'b0010,
    ST_PUSH_HI = 4'b0011,
    ST_ROT     = 4'b0100,
    ST_REP_CHK = 4'b0101,
    ST_REP_INT = 4'b0110,
    ST_REP_STR = 4'b0111
  } exec_state_type;

  // Byte write request toward system memory
  typedef struct packed {
    logic        valid;
    logic [15:0] addr;
    logic [7:0]  data;
  } mem_req_type;

  // Answer of the string primitive unit
  typedef struct packed {
    logic ack;
    logic zero_flag;
    logic compare;
  } str_resp_type;

endpackage

//--- bench/exec_assertions.sv
// Checker for stack byte writes, string element and interrupt handshakes.
// Bound to the exec block by the bench; reads only its ports.
`timescale 1ns/100ps
`default_nettype none
module exec_assertions
  import exec_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire mem_req_type  mem_req,
  input wire logic         mem_ready,
  input wire logic         str_req,
  input wire str_resp_type str_resp,
  input wire logic         irq,
  input wire logic         nmi,
  input wire logic         int_req,
  input wire logic         int_done
);
  logic hi_q;
  logic hi_d;
  // Marks the second byte of a pair; a lost toggle breaks the order check
  assign hi_d = hi_q ^ (mem_req.valid & mem_ready);
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      hi_q <= 1'b0;
    else
      hi_q <= hi_d;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mem_req_held: assert property (mem_req.valid && !mem_ready |=> $stable(mem_req))
    else $error("memory request moved before it was taken");
  a_high_byte_next: assert property (mem_req.valid && mem_ready && !hi_q
    |=> mem_req.valid && mem_req.addr == $past(mem_req.addr) + 16'h0001)
    else $error("high stack byte not at next address");
  a_pair_closes: assert property (mem_req.valid && mem_ready && hi_q |=> !mem_req.valid)
    else $error("stack write longer than one word");
  a_str_req_held: assert property (str_req && !str_resp.ack |=> str_req)
    else $error("element request dropped without answer");
  a_count_step: assert property (str_req && str_resp.ack |=> !str_req)
    else $error("next element issued without a count step");
  a_int_req_held: assert property (int_req && !int_done |=> int_req)
    else $error("interrupt request dropped before return");
  a_int_between: assert property (!(int_req && str_req))
    else $error("interrupt raised inside an element");
  a_int_has_cause: assert property ($rose(int_req) |-> $past(irq) || $past(nmi))
    else $error("interrupt service without a source");
endmodule
`default_nettype wire

//--- bench/exec_far_model.sv
// Far side of the exec block: byte memory, string primitive unit and
// interrupt controller. The bench steers delay, primitive kind and results.
`timescale 1ns/100ps
`default_nettype none
module exec_far_model
  import exec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire mem_req_type mem_req,
  output logic             mem_ready,
  input  wire logic        str_req,
  output str_resp_type     str_resp,
  input  wire logic        int_req,
  output logic             int_done,
  input  wire logic        slow,
  input  wire logic        is_cmp,
  input  wire logic [15:0] zf_seq,
  output logic [7:0]       n_elem
);
  logic [1:0] tick_q;
  logic       ack_q;
  logic       go;
  logic       zf;
  // Slow mode answers one cycle in four, so the block must hold its request
  assign go = !slow || tick_q == 2'd3;
  assign mem_ready = go && mem_req.valid;
  assign zf = zf_seq[n_elem[3:0]];
  // Outside an answer the flag line shows the inverse, never a stale result
  assign str_resp = '{ack: ack_q, zero_flag: ack_q ? zf : !zf, compare: is_cmp};
  // One-cycle answers, only while a request stands
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tick_q <= 2'd0;
      ack_q <= 1'b0;
      int_done <= 1'b0;
      n_elem <= 8'h00;
    end
    else
    begin
      tick_q <= tick_q + 2'd1;
      ack_q <= str_req && !ack_q && go;
      int_done <= int_req && !int_done && go;
      n_elem <= n_elem + {7'h00, ack_q};
    end
endmodule
`default_nettype wire

//--- bench/stack_push_rotate_repeat_exec_tb_top.sv
// Self-checking bench: APB master, far-side model, queued expectations.
// Assumes the zero-wait APB slave and register map of exec_pkg.
`timescale 1ns/100ps
`default_nettype none
module stack_push_rotate_repeat_exec_tb_top
  import exec_pkg::*;
;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [11:0]  paddr = 12'h000;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  mem_req_type  mem_req;
  logic         mem_ready;
  logic         str_req;
  logic         str_extra;
  str_resp_type str_resp;
  logic         irq = 1'b0;
  logic         nmi = 1'b0;
  logic         int_req;
  logic         int_nmi;
  logic         int_done;
  logic         slow = 1'b0;
  logic         is_cmp = 1'b0;
  logic [15:0]  zf_seq = 16'h0;
  logic [7:0]   n_elem;
  logic [1:0]   want = 2'b00;
  logic         arm = 1'b0;
  logic         exp_extra = 1'b0;
  logic         err;
  logic [32:0]  note;
  logic [32:0]  rd_q[$];
  logic [23:0]  mem_q[$];
  int           n_int = 0;
  int           n_mismatch = 0;
  int           compares = 0;
  int           cyc = 0;
  // Table: extra prefix, repeat byte, opcode, count, {nmi, irq}, IF, 0
  localparam logic [31:0] REP_TAB [7] = '{32'h00f3a450, 32'h00f3a680, 32'h00f2ae80,
    32'h00f3aa00, 32'h26f3a446, 32'h26f3a538, 32'h00f3ab34};

  stack_push_rotate_repeat_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_ready(mem_ready),
    .str_req(str_req), .str_extra(str_extra), .str_resp(str_resp), .irq(irq), .nmi(nmi),
    .int_req(int_req), .int_nmi(int_nmi), .int_done(int_done));
  exec_far_model far (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_ready(mem_ready), .str_req(str_req), .str_resp(str_resp), .int_req(int_req),
    .int_done(int_done), .slow(slow), .is_cmp(is_cmp), .zf_seq(zf_seq), .n_elem(n_elem));

  // Clock and a hang limit well above the expected run length
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_mismatch++;
      complete_run();
    end
  end

  // *****************************************
  // Shared tasks
  // *****************************************
  task automatic complete_run();
    $display("compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One transfer and an idle cycle, so no signal is driven twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic c, output logic [31:0] r);
    if (!w)
      rd_q.push_back({c, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 1'b0, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, e, 1'b1, r);
  endtask
  // Start an instruction, then poll until idle with done set
  task automatic run(input logic [31:0] ins);
    logic [31:0] s;
    int          n;
    wr(INSTR_OFS, ins);
    wr(CTRL_OFS, 32'h1);
    n = 0;
    do
    begin
      apb(1'b0, STATUS_OFS, 32'h0, 1'b0, s);
      n++;
    end
    while (s[1:0] != 2'b10 && n < 400);
    chk(s[1:0], 2'b10);
  endtask
  function automatic logic [17:0] rot(input logic [15:0] v, input logic c,
                                      input logic [7:0] n, input logic right);
    logic [16:0] x;
    x = {c, v};
    repeat (n) x = right ? {x[0], x[16:1]} : {x[15:0], x[16]};
    return {right ? x[15] ^ x[14] : x[15] ^ x[16], x};
  endfunction

  // Watchers take the oldest note whenever a result shows
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      note = rd_q.pop_front();
      if (note[32])
        chk(prdata, note[31:0]);
    end
    if (mem_req.valid && mem_ready)
      chk({8'h0, mem_req.addr, mem_req.data}, {8'h0, mem_q.pop_front()});
  end
  always @(posedge pclk)
  begin
    if (str_req && str_resp.ack)
    begin
      chk(str_extra, exp_extra);
      if (arm)
        {arm, nmi, irq} <= {1'b0, want};
    end
    if (int_req)
      {nmi, irq} <= 2'b00;
    if (int_req && int_done)
    begin
      chk(int_nmi, want[1]);
      exp_extra = 1'b0;
      n_int++;
    end
  end

  initial
  begin
    logic [31:0] f, v, ins;
    logic [17:0] x;
    logic [15:0] sp, zs;
    logic [11:0] src;
    logic [7:0]  cl, b;
    logic [2:0]  r;
    int          e;
    void'($urandom(49604));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Register, code segment, general and flag pushes; odd passes stall memory
    for (int k = 0; k < 4; k++)
    begin
      r = 3'($urandom % 7);
      if (r > 3'd3)
        r++;
      v = $urandom & 32'h0000_ffff;
      sp = 16'($urandom);
      f = $urandom & 32'h0000_0dd5;
      slow <= k[0];
      src = k == 1 ? SEG_BASE + 12'h004 : GPR_BASE + {7'h00, r, 2'b00};
      ins = k == 0 ? {24'h0, 5'b01010, r} : k == 1 ? 32'h0e
          : k == 2 ? {16'h0, 2'b11, 3'b110, r, 8'hff} : 32'h9d;
      if (k == 3)
        v = f;
      wr(FLAGS_OFS, f);
      wr(GPR_BASE + 12'h010, {16'h0, sp});
      if (k != 3)
        wr(src, v);
      mem_q.push_back({sp - 16'h0002, v[7:0]});
      mem_q.push_back({sp - 16'h0001, v[15:8]});
      run(ins);
      rd(GPR_BASE + 12'h010, {16'h0, sp - 16'h0002});
      rd(FLAGS_OFS, f);
    end
    $display("push tests done");
    // Carry rotates by one, by a zero count and by random counts
    for (int k = 0; k < 12; k++)
    begin
      r = 3'd2 + {2'b00, k[1]};
      cl = k < 4 ? 8'h01 : k < 6 ? 8'h00 : 8'($urandom % 18);
      v = $urandom & 32'h0000_ffff;
      f = $urandom & 32'h0000_0dd5;
      x = rot(v[15:0], f[0], cl, k[0]);
      wr(FLAGS_OFS, f);
      wr(GPR_BASE + 12'h004, {16'h0, 8'($urandom), cl});
      wr(GPR_BASE + {7'h00, r, 2'b00}, v);
      run({16'h0, 2'b11, k[0] ? 3'b011 : 3'b010, r, 6'b110100, k >= 4, 1'b1});
      rd(GPR_BASE + {7'h00, r, 2'b00}, {16'h0, x[15:0]});
      rd(FLAGS_OFS, {20'h0, cl == 8'h01 ? x[17] : f[11], f[10:1], x[16]});
    end
    $display("rotate tests done");
    // Repeated string runs: both forms, zero count, interrupts mid-run
    for (int k = 0; k < 7; k++)
    begin
      ins = REP_TAB[k];
      zs = 16'($urandom);
      zf_seq <= zs;
      is_cmp <= &ins[10:9];
      b = n_elem;
      v = {zs, zs} >> b[3:0];
      e = 0;
      while (e < ins[7:4] && !(e > 0 && ins[10] && ins[9] && v[e-1] != ins[16]))
        e++;
      f = ($urandom & 32'h0000_0dd5) | {22'h0, ins[1], 9'h0};
      wr(FLAGS_OFS, f);
      wr(GPR_BASE + 12'h004, {28'h0, ins[7:4]});
      want = ins[3:2];
      arm = |ins[3:2];
      exp_extra = |ins[31:24];
      n_int = 0;
      run({ins[31:16], 8'h00, ins[15:8]});
      rd(GPR_BASE + 12'h004, {28'h0, ins[7:4] - 4'(e)});
      chk(n_elem - b, 8'(e));
      chk(n_int, {31'h0, ins[3] | (ins[2] & ins[1])});
      rd(FLAGS_OFS, (e == 0 || !ins[10] || !ins[9]) ? f : {f[31:7], v[e-1], f[5:0]});
    end
    $display("repeat tests done");
    rd(12'h0fc, 32'h0);
    chk(err, 1'b1);
    complete_run();
  end
endmodule

bind stack_push_rotate_repeat_exec exec_assertions u_check (.pclk(pclk), .presetn(presetn),
  .mem_req(mem_req), .mem_ready(mem_ready), .str_req(str_req), .str_resp(str_resp),
  .irq(irq), .nmi(nmi), .int_req(int_req), .int_done(int_done));
`default_nettype wire
